// [cache_leaf_table.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ident_map.svh"

module cache_leaf_table (
    ident_if.cache_mp cq
);
    // Example cache hierarchy; figures are plain defaults
    localparam ident_pkg::cache_desc_s CACHE_TABLE [`CACHE_ENTRIES] = '{
        '{`CACHE_TYPE_DATA,    3'h1, 1'b1, 1'b0, 12'h001, 6'h03, 12'h03F, 10'h000,
          10'h007, 32'h0000_003F, 1'b0, 1'b0, 1'b0},
        '{`CACHE_TYPE_INSTR,   3'h1, 1'b1, 1'b0, 12'h001, 6'h03, 12'h03F, 10'h000,
          10'h003, 32'h0000_007F, 1'b0, 1'b0, 1'b0},
        '{`CACHE_TYPE_UNIFIED, 3'h2, 1'b1, 1'b0, 12'h001, 6'h03, 12'h03F, 10'h000,
          10'h007, 32'h0000_01FF, 1'b0, 1'b0, 1'b0},
        '{`CACHE_TYPE_UNIFIED, 3'h3, 1'b1, 1'b0, 12'h00F, 6'h03, 12'h03F, 10'h000,
          10'h00F, 32'h0000_0FFF, 1'b1, 1'b1, 1'b1}
    };

    ident_pkg::cache_desc_s sel;

    // Pick the entry; past the end reports the null type, all fields zero
    always_comb begin
        sel = '0;
        if (cq.sub_index < `CACHE_ENTRIES) begin
            sel = CACHE_TABLE[cq.sub_index[1:0]];
        end
    end

    // Pack the four answer words; reserved positions stay zero
    always_comb begin
        cq.type_level_word = 32'h0000_0000;
        cq.type_level_word[`CT_TYPE_LSB +: 5]     = sel.cache_type;
        cq.type_level_word[`CT_LEVEL_LSB +: 3]    = sel.level;
        cq.type_level_word[`CT_SELF_INIT_BIT]     = sel.self_init;
        cq.type_level_word[`CT_FULL_ASSOC_BIT]    = sel.fully_assoc;
        cq.type_level_word[`CT_SHARE_IDS_LSB +: 12] = sel.share_ids;
        cq.type_level_word[`CT_CORE_IDS_LSB +: 6] = sel.core_ids;
        cq.geometry_word = 32'h0000_0000;
        cq.geometry_word[`CG_LINE_SIZE_LSB +: 12] = sel.line_size;
        cq.geometry_word[`CG_PARTITIONS_LSB +: 10] = sel.partitions;
        cq.geometry_word[`CG_WAYS_LSB +: 10]      = sel.ways;
        cq.set_count_word = sel.sets;
        cq.policy_word = 32'h0000_0000;
        cq.policy_word[`CP_WB_INVAL_BIT]    = sel.wb_inval_nonorig;
        cq.policy_word[`CP_INCLUSIVE_BIT]   = sel.inclusive;
        cq.policy_word[`CP_COMPLEX_IDX_BIT] = sel.complex_index;
    end
endmodule

`default_nettype wire

// [feature_word_builder.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ident_map.svh"

module feature_word_builder (
    ident_if.feat_mp fw
);
    // Copy supported flags into their documented positions; rest stays zero
    always_comb begin
        fw.feature_word = 32'h0000_0000;
        fw.feature_word[`FB_SIMD_GEN3]        = fw.feature_support[`FB_SIMD_GEN3];
        fw.feature_word[`FB_CARRYLESS_MUL]    = fw.feature_support[`FB_CARRYLESS_MUL];
        fw.feature_word[`FB_WIDE_DEBUG_STORE] = fw.feature_support[`FB_WIDE_DEBUG_STORE];
        fw.feature_word[`FB_MONITOR_WAIT]     = fw.feature_support[`FB_MONITOR_WAIT];
        fw.feature_word[`FB_PRIV_DEBUG_STORE] = fw.feature_support[`FB_PRIV_DEBUG_STORE];
        fw.feature_word[`FB_VIRT_MACHINE]     = fw.feature_support[`FB_VIRT_MACHINE];
        fw.feature_word[`FB_SAFER_MODE]       = fw.feature_support[`FB_SAFER_MODE];
        fw.feature_word[`FB_FREQ_STEPPING]    = fw.feature_support[`FB_FREQ_STEPPING];
        fw.feature_word[`FB_THERMAL_TWO]      = fw.feature_support[`FB_THERMAL_TWO];
        fw.feature_word[`FB_SUPPL_SIMD]       = fw.feature_support[`FB_SUPPL_SIMD];
        fw.feature_word[`FB_L1_CONTEXT]       = fw.feature_support[`FB_L1_CONTEXT];
        fw.feature_word[`FB_ADV_VECTOR]       = fw.feature_support[`FB_ADV_VECTOR];
        fw.feature_word[`FB_WIDE_CMPXCHG]     = fw.feature_support[`FB_WIDE_CMPXCHG];
        fw.feature_word[`FB_PRIO_UPDATE_CTRL] = fw.feature_support[`FB_PRIO_UPDATE_CTRL];
        fw.feature_word[`FB_PERF_DEBUG_CAP]   = fw.feature_support[`FB_PERF_DEBUG_CAP];
        fw.feature_word[`FB_PROC_CONTEXT_ID]  = fw.feature_support[`FB_PROC_CONTEXT_ID];
        fw.feature_word[`FB_DEVICE_PREFETCH]  = fw.feature_support[`FB_DEVICE_PREFETCH];
        fw.feature_word[`FB_SIMD_GEN4_FIRST]  = fw.feature_support[`FB_SIMD_GEN4_FIRST];
        fw.feature_word[`FB_SIMD_GEN4_SECOND] = fw.feature_support[`FB_SIMD_GEN4_SECOND];
        fw.feature_word[`FB_EXT_IRQ_CTRL]     = fw.feature_support[`FB_EXT_IRQ_CTRL];
        fw.feature_word[`FB_BYTE_SWAP_MOVE]   = fw.feature_support[`FB_BYTE_SWAP_MOVE];
        fw.feature_word[`FB_POP_COUNT]        = fw.feature_support[`FB_POP_COUNT];
        fw.feature_word[`FB_BLOCK_CIPHER]     = fw.feature_support[`FB_BLOCK_CIPHER];
        fw.feature_word[`FB_EXT_STATE_SAVE]   = fw.feature_support[`FB_EXT_STATE_SAVE];
        // OS flag only when the save feature exists and the OS turned it on
        fw.feature_word[`FB_OS_EXT_STATE]     = fw.feature_support[`FB_EXT_STATE_SAVE]
                                              & fw.os_ext_state_en;
        fw.feature_word[31]                   = 1'b0;
    end
endmodule

`default_nettype wire

// [ident_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface ident_if;
    logic [31:0] feature_support;
    logic        os_ext_state_en;
    logic [31:0] feature_word;
    logic [31:0] sub_index;
    logic [31:0] type_level_word;
    logic [31:0] geometry_word;
    logic [31:0] set_count_word;
    logic [31:0] policy_word;

    modport feat_mp (
        input  feature_support,
        input  os_ext_state_en,
        output feature_word
    );

    modport cache_mp (
        input  sub_index,
        output type_level_word,
        output geometry_word,
        output set_count_word,
        output policy_word
    );

    modport top_mp (
        output feature_support,
        output os_ext_state_en,
        output sub_index,
        input  feature_word,
        input  type_level_word,
        input  geometry_word,
        input  set_count_word,
        input  policy_word
    );
endinterface

`default_nettype wire

// [ident_map.svh]
`ifndef IDENT_MAP_SVH
`define IDENT_MAP_SVH

// Leaf codes of the identification request
`define LEAF_FEATURES          32'h0000_0001
`define LEAF_CACHE_PARAMS      32'h0000_0004

// Bit positions in the feature word
`define FB_SIMD_GEN3           0
`define FB_CARRYLESS_MUL       1
`define FB_WIDE_DEBUG_STORE    2
`define FB_MONITOR_WAIT        3
`define FB_PRIV_DEBUG_STORE    4
`define FB_VIRT_MACHINE        5
`define FB_SAFER_MODE          6
`define FB_FREQ_STEPPING       7
`define FB_THERMAL_TWO         8
`define FB_SUPPL_SIMD          9
`define FB_L1_CONTEXT          10
`define FB_WIDE_CMPXCHG        13
`define FB_PRIO_UPDATE_CTRL    14
`define FB_PERF_DEBUG_CAP      15
`define FB_PROC_CONTEXT_ID     17
`define FB_DEVICE_PREFETCH     18
`define FB_SIMD_GEN4_FIRST     19
`define FB_SIMD_GEN4_SECOND    20
`define FB_EXT_IRQ_CTRL        21
`define FB_BYTE_SWAP_MOVE      22
`define FB_POP_COUNT           23
`define FB_BLOCK_CIPHER        25
`define FB_EXT_STATE_SAVE      26
`define FB_OS_EXT_STATE        27
`define FB_ADV_VECTOR          28

// Field positions in the cache-parameter words
`define CT_TYPE_LSB            0
`define CT_LEVEL_LSB           5
`define CT_SELF_INIT_BIT       8
`define CT_FULL_ASSOC_BIT      9
`define CT_SHARE_IDS_LSB       14
`define CT_CORE_IDS_LSB        26
`define CG_LINE_SIZE_LSB       0
`define CG_PARTITIONS_LSB      12
`define CG_WAYS_LSB            22
`define CP_WB_INVAL_BIT        0
`define CP_INCLUSIVE_BIT       1
`define CP_COMPLEX_IDX_BIT     2

// Cache type codes
`define CACHE_TYPE_NULL        5'h00
`define CACHE_TYPE_DATA        5'h01
`define CACHE_TYPE_INSTR       5'h02
`define CACHE_TYPE_UNIFIED     5'h03

// Table depth and reset values
`define CACHE_ENTRIES          4
`define RESP_WORD_RST          32'h0000_0000

`endif

// [ident_pkg.sv]
package ident_pkg;

    // One cache level as reported by the cache-parameter leaf
    typedef struct packed {
        logic [4:0]  cache_type;
        logic [2:0]  level;
        logic        self_init;
        logic        fully_assoc;
        logic [11:0] share_ids;
        logic [5:0]  core_ids;
        logic [11:0] line_size;
        logic [9:0]  partitions;
        logic [9:0]  ways;
        logic [31:0] sets;
        logic        wb_inval_nonorig;
        logic        inclusive;
        logic        complex_index;
    } cache_desc_s;

    // Request sequencing
    typedef enum logic [0:0] {
        RESP_IDLE,
        RESP_LOOKUP
    } resp_state_e;

endpackage

// [identify_responder.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ident_map.svh"

module identify_responder #(
    // Supported features, one flag per feature-word position
    parameter logic SUP_SIMD_GEN3        = 1'b1,
    parameter logic SUP_CARRYLESS_MUL    = 1'b1,
    parameter logic SUP_WIDE_DEBUG_STORE = 1'b0,
    parameter logic SUP_MONITOR_WAIT     = 1'b1,
    parameter logic SUP_PRIV_DEBUG_STORE = 1'b0,
    parameter logic SUP_VIRT_MACHINE     = 1'b1,
    parameter logic SUP_SAFER_MODE       = 1'b0,
    parameter logic SUP_FREQ_STEPPING    = 1'b1,
    parameter logic SUP_THERMAL_TWO      = 1'b1,
    parameter logic SUP_SUPPL_SIMD       = 1'b1,
    parameter logic SUP_L1_CONTEXT       = 1'b0,
    parameter logic SUP_WIDE_CMPXCHG     = 1'b1,
    parameter logic SUP_PRIO_UPDATE_CTRL = 1'b1,
    parameter logic SUP_PERF_DEBUG_CAP   = 1'b1,
    parameter logic SUP_PROC_CONTEXT_ID  = 1'b1,
    parameter logic SUP_DEVICE_PREFETCH  = 1'b0,
    parameter logic SUP_SIMD_GEN4_FIRST  = 1'b1,
    parameter logic SUP_SIMD_GEN4_SECOND = 1'b1,
    parameter logic SUP_EXT_IRQ_CTRL     = 1'b1,
    parameter logic SUP_BYTE_SWAP_MOVE   = 1'b0,
    parameter logic SUP_POP_COUNT        = 1'b1,
    parameter logic SUP_BLOCK_CIPHER     = 1'b1,
    parameter logic SUP_EXT_STATE_SAVE   = 1'b1,
    parameter logic SUP_ADV_VECTOR       = 1'b1
) (
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        NRST,
    // Identification request
    input  wire logic        ID_REQ,
    input  wire logic [31:0] ID_LEAF,
    input  wire logic [31:0] ID_SUBLEAF,
    // Operating-system state
    input  wire logic        OS_XSTATE_EN,
    // Answer
    output var  logic        ID_BUSY,
    output var  logic        ID_VALID,
    output var  logic [31:0] FIRST_GENERAL_WORD,
    output var  logic [31:0] SECOND_GENERAL_WORD,
    output var  logic [31:0] THIRD_GENERAL_WORD,
    output var  logic [31:0] FOURTH_GENERAL_WORD,
    // Permission for the process-context id enable
    output var  logic        CTX_ID_EN_ALLOWED
);

    // True when a leaf code matches the given one
    function automatic logic leaf_is(input logic [31:0] leaf, input logic [31:0] code);
        leaf_is = (leaf == code);
    endfunction

    // Gather the support flags into feature-word positions
    function automatic logic [31:0] support_vector();
        logic [31:0] v;
        v = 32'h0000_0000;
        v[`FB_SIMD_GEN3]        = SUP_SIMD_GEN3;
        v[`FB_CARRYLESS_MUL]    = SUP_CARRYLESS_MUL;
        v[`FB_WIDE_DEBUG_STORE] = SUP_WIDE_DEBUG_STORE;
        v[`FB_MONITOR_WAIT]     = SUP_MONITOR_WAIT;
        v[`FB_PRIV_DEBUG_STORE] = SUP_PRIV_DEBUG_STORE;
        v[`FB_VIRT_MACHINE]     = SUP_VIRT_MACHINE;
        v[`FB_SAFER_MODE]       = SUP_SAFER_MODE;
        v[`FB_FREQ_STEPPING]    = SUP_FREQ_STEPPING;
        v[`FB_THERMAL_TWO]      = SUP_THERMAL_TWO;
        v[`FB_SUPPL_SIMD]       = SUP_SUPPL_SIMD;
        v[`FB_L1_CONTEXT]       = SUP_L1_CONTEXT;
        v[`FB_WIDE_CMPXCHG]     = SUP_WIDE_CMPXCHG;
        v[`FB_PRIO_UPDATE_CTRL] = SUP_PRIO_UPDATE_CTRL;
        v[`FB_PERF_DEBUG_CAP]   = SUP_PERF_DEBUG_CAP;
        v[`FB_PROC_CONTEXT_ID]  = SUP_PROC_CONTEXT_ID;
        v[`FB_DEVICE_PREFETCH]  = SUP_DEVICE_PREFETCH;
        v[`FB_SIMD_GEN4_FIRST]  = SUP_SIMD_GEN4_FIRST;
        v[`FB_SIMD_GEN4_SECOND] = SUP_SIMD_GEN4_SECOND;
        v[`FB_EXT_IRQ_CTRL]     = SUP_EXT_IRQ_CTRL;
        v[`FB_BYTE_SWAP_MOVE]   = SUP_BYTE_SWAP_MOVE;
        v[`FB_POP_COUNT]        = SUP_POP_COUNT;
        v[`FB_BLOCK_CIPHER]     = SUP_BLOCK_CIPHER;
        v[`FB_EXT_STATE_SAVE]   = SUP_EXT_STATE_SAVE;
        v[`FB_ADV_VECTOR]       = SUP_ADV_VECTOR;
        support_vector = v;
    endfunction

    ident_if id_bus ();

    ident_pkg::resp_state_e state_ff;
    ident_pkg::resp_state_e nxt_state;
    logic [31:0]            leaf_ff;
    logic [31:0]            sub_ff;
    logic                   os_en_ff;
    logic                   busy_ff;
    logic                   valid_ff;
    logic [31:0]            word1_ff;
    logic [31:0]            word2_ff;
    logic [31:0]            word3_ff;
    logic [31:0]            word4_ff;
    logic                   ctx_id_ok_ff;
    logic [31:0]            nxt_word1;
    logic [31:0]            nxt_word2;
    logic [31:0]            nxt_word3;
    logic [31:0]            nxt_word4;
    logic                   take_req;

    // Sub-units see only the captured request, never the live inputs
    assign id_bus.feature_support = support_vector();
    assign id_bus.os_ext_state_en = os_en_ff;
    assign id_bus.sub_index       = sub_ff;

    feature_word_builder u_feat (
        .fw (id_bus.feat_mp)
    );

    cache_leaf_table u_cache (
        .cq (id_bus.cache_mp)
    );

    // A request is taken only while idle; one in flight ignores others
    assign take_req = ID_REQ && (state_ff == ident_pkg::RESP_IDLE);

    // Sequencing: capture, then answer one cycle later
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ident_pkg::RESP_IDLE: begin
                if (take_req) begin
                    nxt_state = ident_pkg::RESP_LOOKUP;
                end
            end
            ident_pkg::RESP_LOOKUP: begin
                nxt_state = ident_pkg::RESP_IDLE;
            end
            default: begin
                nxt_state = ident_pkg::RESP_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            state_ff <= ident_pkg::RESP_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Request capture; nothing else in the block changes on a read
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            leaf_ff  <= 32'h0000_0000;
            sub_ff   <= 32'h0000_0000;
            os_en_ff <= 1'b0;
        end else if (take_req) begin
            leaf_ff  <= ID_LEAF;
            sub_ff   <= ID_SUBLEAF;
            os_en_ff <= OS_XSTATE_EN;
        end
    end

    // Leaf selection; unknown leaves answer all zero
    always_comb begin
        nxt_word1 = `RESP_WORD_RST;
        nxt_word2 = `RESP_WORD_RST;
        nxt_word3 = `RESP_WORD_RST;
        nxt_word4 = `RESP_WORD_RST;
        if (leaf_is(leaf_ff, `LEAF_FEATURES)) begin
            nxt_word3 = id_bus.feature_word;
        end else if (leaf_is(leaf_ff, `LEAF_CACHE_PARAMS)) begin
            nxt_word1 = id_bus.type_level_word;
            nxt_word2 = id_bus.geometry_word;
            nxt_word3 = id_bus.set_count_word;
            nxt_word4 = id_bus.policy_word;
        end
    end

    // Answer words load at the end of lookup and hold until the next answer
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            word1_ff <= `RESP_WORD_RST;
            word2_ff <= `RESP_WORD_RST;
            word3_ff <= `RESP_WORD_RST;
            word4_ff <= `RESP_WORD_RST;
        end else if (state_ff == ident_pkg::RESP_LOOKUP) begin
            word1_ff <= nxt_word1;
            word2_ff <= nxt_word2;
            word3_ff <= nxt_word3;
            word4_ff <= nxt_word4;
        end
    end

    // Handshake flags
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            busy_ff  <= 1'b0;
            valid_ff <= 1'b0;
        end else begin
            busy_ff  <= (nxt_state == ident_pkg::RESP_LOOKUP);
            valid_ff <= (state_ff == ident_pkg::RESP_LOOKUP);
        end
    end

    // The context-id enable may be set only when the feature is reported
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            ctx_id_ok_ff <= 1'b0;
        end else begin
            ctx_id_ok_ff <= SUP_PROC_CONTEXT_ID;
        end
    end

    // Outputs straight from flip-flops
    assign ID_BUSY             = busy_ff;
    assign ID_VALID            = valid_ff;
    assign FIRST_GENERAL_WORD  = word1_ff;
    assign SECOND_GENERAL_WORD = word2_ff;
    assign THIRD_GENERAL_WORD  = word3_ff;
    assign FOURTH_GENERAL_WORD = word4_ff;
    assign CTX_ID_EN_ALLOWED   = ctx_id_ok_ff;

endmodule

`default_nettype wire

// [identify_responder_assertions.sv]
`timescale 1ns/1ps
`default_nettype none

module identify_responder_checker (
    // Clock and reset
    input wire logic        CLOCK,
    input wire logic        NRST,
    // Request
    input wire logic        ID_REQ,
    input wire logic [31:0] ID_LEAF,
    input wire logic [31:0] ID_SUBLEAF,
    input wire logic        OS_XSTATE_EN,
    // Answer
    input wire logic        ID_BUSY,
    input wire logic        ID_VALID,
    input wire logic [31:0] FIRST_GENERAL_WORD,
    input wire logic [31:0] SECOND_GENERAL_WORD,
    input wire logic [31:0] THIRD_GENERAL_WORD,
    input wire logic [31:0] FOURTH_GENERAL_WORD,
    input wire logic        CTX_ID_EN_ALLOWED
);
    logic        take;
    logic [31:0] leaf_ff;
    logic        os_ff;

    // A request is taken only while the responder is idle
    assign take = ID_REQ && !ID_BUSY;

    // Leaf and OS state of the request in flight
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            leaf_ff <= 32'h0;
            os_ff   <= 1'b0;
        end else if (take) begin
            leaf_ff <= ID_LEAF;
            os_ff   <= OS_XSTATE_EN;
        end
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!NRST);

    // Handshake timing
    a_busy_after_take: assert property (take |=> ID_BUSY ##1 !ID_BUSY)
        else $error("busy not one cycle after take");
    a_valid_two_later: assert property (take |=> !ID_VALID ##1 ID_VALID)
        else $error("answer not two cycles after take");
    a_valid_needs_busy: assert property (ID_VALID |-> $past(ID_BUSY, 1))
        else $error("answer without lookup");
    a_valid_one_cycle: assert property (ID_VALID |=> !ID_VALID)
        else $error("answer pulse too long");
    // Outside an answer, words may drop to zero only through a reset, so skip the edge after one
    a_words_hold: assert property (
        !ID_VALID && $past(NRST) |-> $stable({FIRST_GENERAL_WORD,
        SECOND_GENERAL_WORD, THIRD_GENERAL_WORD, FOURTH_GENERAL_WORD}))
        else $error("answer words moved outside an answer");

    // Feature word content
    a_reserved_zero: assert property (ID_VALID && leaf_ff == 32'h1 |->
        THIRD_GENERAL_WORD[31:29] == 3'h0 && THIRD_GENERAL_WORD[24] == 1'b0 &&
        THIRD_GENERAL_WORD[16] == 1'b0 && THIRD_GENERAL_WORD[12:11] == 2'h0)
        else $error("reserved feature bit set");
    a_os_state_gate: assert property (ID_VALID && leaf_ff == 32'h1 |->
        THIRD_GENERAL_WORD[27] == (os_ff & THIRD_GENERAL_WORD[26]))
        else $error("os extended state bit wrong");
    a_ctx_id_permit: assert property (ID_VALID && leaf_ff == 32'h1 |->
        THIRD_GENERAL_WORD[17] == CTX_ID_EN_ALLOWED)
        else $error("context id permission differs from feature bit");

    // Cache word content
    a_cache_type_legal: assert property (ID_VALID && leaf_ff == 32'h4 |->
        FIRST_GENERAL_WORD[4:0] <= 5'h03 && FIRST_GENERAL_WORD[13:10] == 4'h0)
        else $error("cache type or reserved field wrong");

    // Main scenarios
    c_feature_leaf: cover property (take && ID_LEAF == 32'h1);
    c_cache_leaf: cover property (take && ID_LEAF == 32'h4);
    c_refused: cover property (ID_REQ && ID_BUSY);
endmodule

bind identify_responder identify_responder_checker chk (
    .CLOCK               (CLOCK),
    .NRST                (NRST),
    .ID_REQ              (ID_REQ),
    .ID_LEAF             (ID_LEAF),
    .ID_SUBLEAF          (ID_SUBLEAF),
    .OS_XSTATE_EN        (OS_XSTATE_EN),
    .ID_BUSY             (ID_BUSY),
    .ID_VALID            (ID_VALID),
    .FIRST_GENERAL_WORD  (FIRST_GENERAL_WORD),
    .SECOND_GENERAL_WORD (SECOND_GENERAL_WORD),
    .THIRD_GENERAL_WORD  (THIRD_GENERAL_WORD),
    .FOURTH_GENERAL_WORD (FOURTH_GENERAL_WORD),
    .CTX_ID_EN_ALLOWED   (CTX_ID_EN_ALLOWED)
);

`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic        CLOCK = 1'b0;
    logic        NRST = 1'b0;
    logic        ID_REQ = 1'b0;
    logic [31:0] ID_LEAF = 32'h0;
    logic [31:0] ID_SUBLEAF = 32'h0;
    logic        OS_XSTATE_EN = 1'b0;
    logic        id_busy, id_valid, ctx_ok;
    logic [31:0] w0, w1, w2, w3, r;
    logic [31:0] rng = 32'hB718;
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          cycles = 0;
    // Supported feature positions and the cache table of the default build
    int          fset [$] = '{0, 1, 3, 5, 7, 8, 9, 13, 14, 15, 17, 19, 20, 21, 23, 25, 26, 28};
    int          typ [4] = '{1, 2, 3, 3};
    int          lvl [4] = '{1, 1, 2, 3};
    int          shr [4] = '{1, 1, 1, 15};
    int          ways [4] = '{7, 3, 7, 15};
    int          sets [4] = '{63, 127, 511, 4095};
    int          pol [4] = '{0, 0, 0, 7};

    identify_responder uut (
        .CLOCK               (CLOCK),
        .NRST                (NRST),
        .ID_REQ              (ID_REQ),
        .ID_LEAF             (ID_LEAF),
        .ID_SUBLEAF          (ID_SUBLEAF),
        .OS_XSTATE_EN        (OS_XSTATE_EN),
        .ID_BUSY             (id_busy),
        .ID_VALID            (id_valid),
        .FIRST_GENERAL_WORD  (w0),
        .SECOND_GENERAL_WORD (w1),
        .THIRD_GENERAL_WORD  (w2),
        .FOURTH_GENERAL_WORD (w3),
        .CTX_ID_EN_ALLOWED   (ctx_ok)
    );

    // Clock and hang guard
    always #20 CLOCK = ~CLOCK;
    always @(posedge CLOCK) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            conclude();
        end
    end

    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    // Expected answer word k for a request
    function automatic logic [31:0] model(logic [31:0] leaf, logic [31:0] sub, logic os, int k);
        int v;
        v = 0;
        if (leaf == 1 && k == 2) begin
            foreach (fset[i]) v |= 1 << fset[i];
            if (os) v |= 1 << 27;
        end else if (leaf == 4 && sub < 4) begin
            case (k)
                0: v = typ[sub] | lvl[sub] << 5 | 1 << 8 | shr[sub] << 14 | 3 << 26;
                1: v = 63 | ways[sub] << 22;
                2: v = sets[sub];
                default: v = pol[sub];
            endcase
        end
        return v;
    endfunction

    task automatic check(string name, logic [31:0] exp, logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One request; junk keeps the strobe up with other values while busy
    task automatic ask(logic [31:0] leaf, logic [31:0] sub, logic os, logic junk);
        logic [31:0] got [4];
        ID_REQ = 1'b1;
        ID_LEAF = leaf;
        ID_SUBLEAF = sub;
        OS_XSTATE_EN = os;
        @(negedge CLOCK);
        check("busy", 32'h1, {31'h0, id_busy});
        ID_REQ = junk;
        ID_LEAF = xs();
        ID_SUBLEAF = xs();
        OS_XSTATE_EN = ~os;
        @(negedge CLOCK);
        check("valid", 32'h1, {31'h0, id_valid});
        got = '{w0, w1, w2, w3};
        for (int k = 0; k < 4; k++) begin
            check("word", model(leaf, sub, os, k), got[k]);
        end
    endtask

    task automatic idle_zero();
        check("flags", 32'h0, {30'h0, id_busy, id_valid});
        check("words", 32'h0, w0 | w1 | w2 | w3);
    endtask

    task conclude();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (6) @(negedge CLOCK);
        idle_zero();
        NRST = 1'b1;
        @(negedge CLOCK);
        check("ctx_id_ok", 32'h1, {31'h0, ctx_ok});
        // Every table entry and two null entries, some with refused strobes
        for (int s = 0; s < 6; s++) ask(32'h4, s, 1'b0, s[0]);
        ask(32'h1, 32'h0, 1'b0, 1'b1);
        ask(32'h1, 32'h0, 1'b1, 1'b0);
        ask(32'h2, 32'h0, 1'b1, 1'b0);
        // Random leaves and sub-indices, repeats included
        repeat (40) begin
            r = xs();
            ask(r[2] ? 32'h4 : (r[3] ? 32'h1 : r), xs() & 32'h7, r[4], r[5]);
            if (r[6]) begin
                ID_REQ = 1'b0;
                @(negedge CLOCK);
            end
        end
        // Reset in mid-run, then a fresh read
        ID_REQ = 1'b0;
        NRST = 1'b0;
        @(negedge CLOCK);
        idle_zero();
        NRST = 1'b1;
        @(negedge CLOCK);
        check("ctx_id_ok", 32'h1, {31'h0, ctx_ok});
        ask(32'h4, 32'h3, 1'b0, 1'b0);
        conclude();
    end
endmodule

`default_nettype wire
